// File: dctc_host_ctrl.sv
/*
  dctc_host_ctrl: host-side command issuer for a ddr3 memory that holds
  every request until all spacing limits are met, and drives the memory
  clock and clock enable around self-refresh and power-down.
  Assumes the requester sits on ref_clk and holds req_valid and its
  fields steady until req_ack pulses.
*/
`timescale 1ns/1ps

module dctc_host_ctrl
  import dctc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic [3:0] req_cmd,
  input wire logic [2:0] req_bank,
  input wire logic [15:0] req_addr,
  output logic req_ack,
  output logic sleep_active,
  output logic mem_ck,
  output logic mem_ck_n,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [2:0] mem_ba,
  output logic [15:0] mem_addr
);

  // saturating count-down used by every spacing counter
  function automatic logic [5:0] dec(input logic [5:0] v);
    logic [5:0] r;
    r = (v == 6'h00) ? v : v - 6'h01;
    return r;
  endfunction

  dctc_state_t st_q, st_d;
  logic phase_q, phase_d;
  logic run_q, run_d;
  logic ck_q, ck_d;
  logic ck_n_q, ck_n_d;
  logic cke_q, cke_d;
  logic sleep_q, sleep_d;
  logic [3:0] pins_q, pins_d;
  logic [2:0] ba_q, ba_d;
  logic [15:0] addr_q, addr_d;
  logic ack_q, ack_d;
  logic sr_q, sr_d;
  logic [5:0] act_gap_q, act_gap_d;
  logic [5:0] col_gap_q, col_gap_d;
  logic [5:0] rd_gap_q, rd_gap_d;
  logic [5:0] mrs_gap_q, mrs_gap_d;
  logic [5:0] mod_gap_q, mod_gap_d;
  logic [5:0] any_gap_q, any_gap_d;
  logic [5:0] ref_gap_q, ref_gap_d;
  logic [5:0] xs_gap_q, xs_gap_d;
  logic [5:0] cke_low_q, cke_low_d;
  logic [5:0] clk_wait_q, clk_wait_d;
  logic [5:0] pre_wait_q [BANKS];
  logic [5:0] pre_wait_d [BANKS];
  logic [5:0] act_wait_q [BANKS];
  logic [5:0] act_wait_d [BANKS];
  logic [5:0] faw_q [FAW_SLOTS];
  logic [5:0] faw_d [FAW_SLOTS];
  logic tick;
  logic faw_free;
  logic [1:0] faw_slot;
  logic common_ok;
  logic go;
  logic ap;
  logic iss_act, iss_col, iss_rd, iss_wr, iss_mrs, iss_ref, iss_any;

  // one memory clock per two reference cycles; 50 ns is far above the
  // 8 ns floor of delay-loop-off mode, so the divider serves with the delay loop off
  assign tick = phase_q;

  // four-activate window: a slot at zero is a free activate credit
  always_comb
  begin
    faw_free = 1'b0;
    faw_slot = 2'h0;
    for (int i = FAW_SLOTS - 1; i >= 0; i--)
    begin
      if (faw_q[i] == 6'h00)
      begin
        faw_free = 1'b1;
        faw_slot = 2'(i);
      end
    end
  end

  // limits shared by every non-mode command
  assign common_ok = (mod_gap_q == 6'h00) && (any_gap_q == 6'h00) && (xs_gap_q == 6'h00);
  assign ap = req_addr[AP_BIT];

  // gate each request on all its counters before it may go out
  always_comb
  begin
    go = 1'b0;
    if (tick && req_valid && !ack_q && st_q == ST_RUN)
    begin
      unique case (req_cmd)
        CMD_ACT: go = common_ok && act_gap_q == 6'h00 && faw_free
          && act_wait_q[req_bank] == 6'h00 && ref_gap_q == 6'h00;
        CMD_RD, CMD_MPR_RD: go = common_ok && col_gap_q == 6'h00
          && rd_gap_q == 6'h00 && act_wait_q[req_bank] == 6'h00;
        CMD_WR: go = common_ok && col_gap_q == 6'h00 && act_wait_q[req_bank] == 6'h00;
        CMD_PRE: go = common_ok && pre_wait_q[req_bank] == 6'h00;
        CMD_REF, CMD_SR_ENTER: go = common_ok && ref_gap_q == 6'h00;
        CMD_PD_ENTER: go = common_ok;
        CMD_MRS: go = mrs_gap_q == 6'h00 && any_gap_q == 6'h00 && xs_gap_q == 6'h00;
        default: go = 1'b0;
      endcase
    end
  end

  assign iss_act = go && req_cmd == CMD_ACT;
  assign iss_rd = go && (req_cmd == CMD_RD || req_cmd == CMD_MPR_RD);
  assign iss_wr = go && req_cmd == CMD_WR;
  assign iss_col = iss_rd || iss_wr;
  assign iss_mrs = go && req_cmd == CMD_MRS;
  assign iss_ref = go && (req_cmd == CMD_REF || req_cmd == CMD_SR_ENTER);
  assign iss_any = go;

  // next state of the counters, pins and sleep sequence
  always_comb
  begin
    st_d = st_q;
    phase_d = ~phase_q;
    run_d = run_q;
    cke_d = cke_q;
    pins_d = pins_q;
    ba_d = ba_q;
    addr_d = addr_q;
    ack_d = 1'b0;
    sr_d = sr_q;
    act_gap_d = act_gap_q;
    col_gap_d = col_gap_q;
    rd_gap_d = rd_gap_q;
    mrs_gap_d = mrs_gap_q;
    mod_gap_d = mod_gap_q;
    any_gap_d = any_gap_q;
    ref_gap_d = ref_gap_q;
    xs_gap_d = xs_gap_q;
    cke_low_d = cke_low_q;
    clk_wait_d = clk_wait_q;
    for (int b = 0; b < BANKS; b++)
    begin
      pre_wait_d[b] = pre_wait_q[b];
      act_wait_d[b] = act_wait_q[b];
    end
    for (int f = 0; f < FAW_SLOTS; f++)
      faw_d[f] = faw_q[f];
    if (tick)
    begin
      // every counter counts memory clocks, one per tick
      act_gap_d = dec(act_gap_q);
      col_gap_d = dec(col_gap_q);
      rd_gap_d = dec(rd_gap_q);
      mrs_gap_d = dec(mrs_gap_q);
      mod_gap_d = dec(mod_gap_q);
      any_gap_d = dec(any_gap_q);
      ref_gap_d = dec(ref_gap_q);
      xs_gap_d = dec(xs_gap_q);
      cke_low_d = dec(cke_low_q);
      clk_wait_d = dec(clk_wait_q);
      for (int b = 0; b < BANKS; b++)
      begin
        pre_wait_d[b] = dec(pre_wait_q[b]);
        act_wait_d[b] = dec(act_wait_q[b]);
      end
      for (int f = 0; f < FAW_SLOTS; f++)
        faw_d[f] = dec(faw_q[f]);
      pins_d = PIN_NOP;
      if (go)
      begin
        ack_d = 1'b1;
        ba_d = req_bank;
        addr_d = req_addr;
        unique case (req_cmd)
          CMD_ACT:
          begin
            pins_d = PIN_ACT;
            act_gap_d = ACT_GAP_NCK;
            faw_d[faw_slot] = FAW_NCK;
          end
          CMD_RD, CMD_MPR_RD:
          begin
            pins_d = PIN_RD;
            col_gap_d = COL_GAP_NCK;
            if (RD_TO_PRE_NCK > pre_wait_q[req_bank])
              pre_wait_d[req_bank] = RD_TO_PRE_NCK;
            if (ap)
              act_wait_d[req_bank] = RDAP_TO_ACT_NCK;
            if (req_cmd == CMD_MPR_RD)
              any_gap_d = MPR_GAP_NCK;
          end
          CMD_WR:
          begin
            pins_d = PIN_WR;
            col_gap_d = COL_GAP_NCK;
            rd_gap_d = WR_TO_RD_NCK;
            pre_wait_d[req_bank] = WR_TO_PRE_NCK;
            if (ap)
              act_wait_d[req_bank] = WRAP_TO_ACT_NCK;
          end
          CMD_PRE:
          begin
            pins_d = PIN_PRE;
            if (RP_NCK > act_wait_q[req_bank])
              act_wait_d[req_bank] = RP_NCK;
          end
          CMD_REF:
          begin
            pins_d = PIN_REF;
            ref_gap_d = RFC_NCK;
          end
          CMD_MRS:
          begin
            pins_d = PIN_MRS;
            mrs_gap_d = MRS_GAP_NCK;
            mod_gap_d = MOD_GAP_NCK;
          end
          CMD_SR_ENTER:
          begin
            // refresh with clock enable low starts self-refresh
            pins_d = PIN_REF;
            cke_d = 1'b0;
            sr_d = 1'b1;
            cke_low_d = SR_LOW_NCK;
            clk_wait_d = CLK_HOLD_NCK;
            st_d = ST_HOLD;
          end
          CMD_PD_ENTER:
          begin
            cke_d = 1'b0;
            sr_d = 1'b0;
            cke_low_d = PD_LOW_NCK;
            clk_wait_d = CLK_HOLD_NCK;
            st_d = ST_HOLD;
          end
          default: ack_d = 1'b0;
        endcase
      end
      // sleep sequence: hold clock, stop it, restore it, then raise enable
      unique case (st_q)
        ST_RUN: st_d = st_d;
        ST_HOLD:
          if (clk_wait_q == 6'h00)
          begin
            run_d = 1'b0;
            st_d = ST_SLEEP;
          end
        ST_SLEEP:
          if (req_valid && !ack_q && req_cmd == CMD_WAKE)
          begin
            run_d = 1'b1;
            clk_wait_d = CLK_PRE_NCK;
            st_d = ST_WAKE;
          end
        ST_WAKE:
          if (clk_wait_q == 6'h00 && cke_low_q == 6'h00)
          begin
            cke_d = 1'b1;
            ack_d = 1'b1;
            if (sr_q)
              xs_gap_d = XS_GAP_NCK;
            st_d = ST_RUN;
          end
        default: st_d = ST_RUN;
      endcase
    end
    // enable rises right after reset; the exit gap only runs once it is high
    if (st_q == ST_RUN && !cke_q)
      cke_d = 1'b1;
    if (xs_gap_q == XS_GAP_NCK && !cke_q)
      xs_gap_d = xs_gap_q;
  end

  // the memory clock falls at the edge where pins change, so the
  // command is steady for half a period before the rising edge
  assign ck_d = run_d & ~phase_q;
  assign ck_n_d = ~ck_d;
  assign sleep_d = ~cke_d;

  // register everything; outputs come straight from these flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= ST_RUN;
      phase_q <= 1'b0;
      run_q <= 1'b1;
      ck_q <= 1'b0;
      ck_n_q <= 1'b1;
      cke_q <= 1'b0;
      sleep_q <= 1'b1;
      pins_q <= PIN_NOP;
      ba_q <= 3'h0;
      addr_q <= 16'h0000;
      ack_q <= 1'b0;
      sr_q <= 1'b0;
      act_gap_q <= 6'h00;
      col_gap_q <= 6'h00;
      rd_gap_q <= 6'h00;
      mrs_gap_q <= 6'h00;
      mod_gap_q <= 6'h00;
      any_gap_q <= 6'h00;
      ref_gap_q <= 6'h00;
      xs_gap_q <= XS_GAP_NCK;
      cke_low_q <= 6'h00;
      clk_wait_q <= 6'h00;
      for (int b = 0; b < BANKS; b++)
      begin
        pre_wait_q[b] <= 6'h00;
        act_wait_q[b] <= 6'h00;
      end
      for (int f = 0; f < FAW_SLOTS; f++)
        faw_q[f] <= 6'h00;
    end
    else
    begin
      st_q <= st_d;
      phase_q <= phase_d;
      run_q <= run_d;
      ck_q <= ck_d;
      ck_n_q <= ck_n_d;
      cke_q <= cke_d;
      sleep_q <= sleep_d;
      pins_q <= pins_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      ack_q <= ack_d;
      sr_q <= sr_d;
      act_gap_q <= act_gap_d;
      col_gap_q <= col_gap_d;
      rd_gap_q <= rd_gap_d;
      mrs_gap_q <= mrs_gap_d;
      mod_gap_q <= mod_gap_d;
      any_gap_q <= any_gap_d;
      ref_gap_q <= ref_gap_d;
      xs_gap_q <= xs_gap_d;
      cke_low_q <= cke_low_d;
      clk_wait_q <= clk_wait_d;
      pre_wait_q <= pre_wait_d;
      act_wait_q <= act_wait_d;
      faw_q <= faw_d;
    end
  end

  assign req_ack = ack_q;
  assign sleep_active = sleep_q;
  assign mem_ck = ck_q;
  assign mem_ck_n = ck_n_q;
  assign mem_cke = cke_q;
  assign mem_cs_n = pins_q[3];
  assign mem_ras_n = pins_q[2];
  assign mem_cas_n = pins_q[1];
  assign mem_we_n = pins_q[0];
  assign mem_ba = ba_q;
  assign mem_addr = addr_q;

  // checks; helper counters give reference cycles since an event
  logic [7:0] since_mrs_q, since_ref_q, since_wr_q;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      since_mrs_q <= 8'hFF;
      since_ref_q <= 8'hFF;
      since_wr_q <= 8'hFF;
    end
    else
    begin
      since_mrs_q <= iss_mrs ? 8'h00 : (since_mrs_q == 8'hFF ? 8'hFF : since_mrs_q + 8'h01);
      since_ref_q <= iss_ref ? 8'h00 : (since_ref_q == 8'hFF ? 8'hFF : since_ref_q + 8'h01);
      since_wr_q <= iss_wr ? 8'h00 : (since_wr_q == 8'hFF ? 8'hFF : since_wr_q + 8'h01);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_clock_held;
    run_q [*8] ##1 run_q [*2];
  endsequence

  sequence s_low_sr;
    !mem_cke [*8];
  endsequence

  chk_act_spacing: assert property (iss_act |=> !iss_act [*7])
    else $error("activates closer than four clocks");
  chk_col_spacing: assert property (iss_col |=> !iss_col [*7])
    else $error("column commands closer than four clocks");
  chk_mrs_spacing: assert property (iss_mrs |=> !iss_mrs [*7])
    else $error("mode register sets closer than four clocks");
  chk_mode_update: assert property (iss_any && !iss_mrs |-> since_mrs_q >= 8'd23)
    else $error("command issued inside mode update time");
  chk_refresh_gap: assert property ((iss_act || iss_ref) |-> since_ref_q >= 8'd11)
    else $error("activate or refresh inside refresh cycle time");
  chk_write_read: assert property (iss_rd |-> since_wr_q >= 8'd25)
    else $error("read too soon after write");
  chk_sr_cke_low: assert property ($fell(mem_cke) && sr_d |-> s_low_sr)
    else $error("self-refresh clock enable low too short");
  chk_clock_hold: assert property ($fell(mem_cke) |-> s_clock_held)
    else $error("clock stopped too soon after sleep entry");
  // only a wake counts; the first rise after reset has no sleep behind it
  chk_clock_restore: assert property ($rose(mem_cke) && $past(st_q == ST_WAKE) |-> $past(run_q, 10) && run_q)
    else $error("clock not stable before sleep exit");

endmodule

// File: dctc_mem_model.sv
/*
  dctc_mem_model: passive model of the ddr3 device on the controller's pins.
  It checks command spacing and clock handling and counts every breach.
  Assumes the controller makes mem_ck itself; the model drives no memory pin, only err_count.
*/
`timescale 1ns/1ps
module dctc_mem_model
  import dctc_pkg::*;
(
  input wire logic mem_ck,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [2:0] mem_ba,
  input wire logic [15:0] mem_addr,
  output int err_count
);
  int cyc = 0, run = 0, post = 0;
  int l_act = -99, l_col = -99, l_wr = -99, l_rd = -99;
  int l_mrs = -99, l_ref = -99, l_exit = -99;
  int wr_b[BANKS] = '{default: -99};
  int rd_b[BANKS] = '{default: -99};
  int ap_due[BANKS] = '{default: 0};
  int faw[FAW_SLOTS] = '{default: -99};
  realtime t_last = 0.0, t_fall = 0.0;
  logic cke_q = 1'b0, sr_q = 1'b0, asleep = 1'b0, hold_open = 1'b0;
  logic [3:0] pins;
  logic dqs_oe;

  assign pins = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  // strobe pair driven one clock before read data until the burst is over
  assign dqs_oe = (cyc - l_rd >= RL_NCK - 1) && (cyc - l_rd < RL_NCK + BURST_NCK);

  initial err_count = 0;

  // one breach is counted once; the message names what was too close
  task automatic need(input int gap, input int lo, input string what);
    if (gap < lo)
    begin
      err_count++;
      $display("memory model: %s gap %0d below %0d at %0t", what, gap, lo, $time);
    end
  endtask

  // every rising memory clock edge: clock health, clock enable, then command spacing
  always @(posedge mem_ck)
  begin
    realtime per;
    per = $realtime - t_last;
    t_last = $realtime;
    cyc++;
    run++;
    if (per < DLL_OFF_MIN_CK_PS / 1000.0)
      need(0, 1, "clock period");
    // a long period means the clock was stopped and has just resumed
    if (per > 1.5 * CK_PS / 1000.0)
    begin
      if (hold_open)
        need(post, int'(CLK_HOLD_NCK), "clock after entry");
      hold_open = 1'b0;
      run = 1;
    end
    if (cke_q && !mem_cke)
    begin
      t_fall = $realtime;
      sr_q = (pins == PIN_REF);
      asleep = 1'b1;
      hold_open = 1'b1;
      post = 0;
    end
    else if (!mem_cke)
      post++;
    else if (asleep)
    begin
      need(run, int'(CLK_PRE_NCK), "clock before exit");
      need(int'(($realtime - t_fall) * 1000.0 / CK_PS),
        sr_q ? int'(SR_LOW_NCK) : int'(PD_LOW_NCK), "enable low width");
      if (sr_q)
        l_exit = cyc;
      asleep = 1'b0;
      hold_open = 1'b0;
    end
    else if (!pins[3] && pins != PIN_NOP)
    begin
      need(cyc - l_exit, int'(XS_GAP_NCK), "self-refresh exit");
      if (pins != PIN_MRS)
        need(cyc - l_mrs, int'(MOD_GAP_NCK), "mode update");
      case (pins)
        PIN_ACT:
        begin
          need(cyc - l_act, int'(ACT_GAP_NCK), "activate");
          need(cyc - faw[0], int'(FAW_NCK), "four activate window");
          need(cyc, ap_due[mem_ba], "auto precharge");
          need(cyc - l_ref, int'(RFC_NCK), "refresh to activate");
          faw = '{faw[1], faw[2], faw[3], cyc};
          l_act = cyc;
        end
        PIN_RD, PIN_WR:
        begin
          need(cyc - l_col, int'(COL_GAP_NCK), "column");
          if (pins == PIN_RD)
            need(cyc - l_wr, int'(WR_TO_RD_NCK), "write to read");
          l_col = cyc;
          if (pins == PIN_RD)
            l_rd = cyc;
          if (pins == PIN_RD)
            rd_b[mem_ba] = cyc;
          else
            wr_b[mem_ba] = cyc;
          if (pins == PIN_WR)
            l_wr = cyc;
          if (mem_addr[AP_BIT])
            ap_due[mem_ba] = cyc + int'(pins == PIN_RD ? RDAP_TO_ACT_NCK : WRAP_TO_ACT_NCK);
        end
        PIN_PRE:
        begin
          need(cyc - wr_b[mem_ba], int'(WR_TO_PRE_NCK), "write recovery");
          need(cyc - rd_b[mem_ba], int'(RD_TO_PRE_NCK), "read to precharge");
        end
        PIN_REF:
        begin
          need(cyc - l_ref, int'(RFC_NCK), "refresh");
          l_ref = cyc;
        end
        PIN_MRS:
        begin
          need(cyc - l_mrs, int'(MRS_GAP_NCK), "mode set");
          l_mrs = cyc;
        end
        default:
          ;
      endcase
    end
    cke_q = mem_cke;
  end
endmodule

// File: dctc_pkg.sv
/*
  dctc_pkg: constants shared by the ddr3 command timing controller.
  Assumes a 40 MHz reference clock; the memory command clock is derived
  from it by a fixed divider, so every figure below is turned into
  memory clock cycles at that derived period.
*/
package dctc_pkg;

  // clocking: reference period and divider that makes the memory clock
  localparam int REF_PS = 25000;
  localparam int CK_DIV = 2;
  localparam int CK_PS = REF_PS * CK_DIV;
  localparam int DLL_OFF_MIN_CK_PS = 8000;

  // device latencies in memory clocks
  localparam int WL_NCK = 5;
  localparam int RL_NCK = 6;
  localparam int BURST_NCK = 4;

  // spacing figures as printed (ps) and their cycle floors
  localparam int RRD_PS = 6000;
  localparam int RRD_NCK = 4;
  localparam int FAW_PS = 30000;
  localparam int CCD_NCK = 4;
  localparam int WR_PS = 15000;
  localparam int RP_PS = 13750;
  localparam int WTR_PS = 7500;
  localparam int WTR_NCK = 4;
  localparam int RTP_PS = 7500;
  localparam int RTP_NCK = 4;
  localparam int MRD_NCK = 4;
  localparam int MOD_PS = 15000;
  localparam int MOD_NCK = 12;
  localparam int MPRR_NCK = 1;
  localparam int CKE_PS = 5000;
  localparam int CKE_NCK = 3;
  localparam int CKESR_EXTRA_NCK = 1;
  localparam int CKSRE_PS = 10000;
  localparam int CKSRE_NCK = 5;
  localparam int CKSRX_PS = 10000;
  localparam int CKSRX_NCK = 5;
  localparam int RFC_PS = 260000;
  localparam int XS_EXTRA_PS = 10000;
  localparam int XS_NCK = 5;

  // round a time up to whole clocks and take the larger of it and a floor
  function automatic int dctc_nck(input int ps, input int floor_nck);
    int c;
    c = (ps + CK_PS - 1) / CK_PS;
    if (c < floor_nck)
      c = floor_nck;
    if (c < 1)
      c = 1;
    return c;
  endfunction

  // cycle counts loaded into the spacing counters
  localparam logic [5:0] ACT_GAP_NCK = 6'(dctc_nck(RRD_PS, RRD_NCK));
  localparam logic [5:0] FAW_NCK = 6'(dctc_nck(FAW_PS, 1));
  localparam logic [5:0] COL_GAP_NCK = 6'(CCD_NCK);
  localparam logic [5:0] WR_NCK = 6'(dctc_nck(WR_PS, 1));
  localparam logic [5:0] RP_NCK = 6'(dctc_nck(RP_PS, 1));
  localparam logic [5:0] WR_TO_PRE_NCK = 6'(WL_NCK + BURST_NCK) + WR_NCK;
  localparam logic [5:0] WRAP_TO_ACT_NCK = WR_TO_PRE_NCK + RP_NCK;
  localparam logic [5:0] WR_TO_RD_NCK = 6'(WL_NCK + BURST_NCK + dctc_nck(WTR_PS, WTR_NCK));
  localparam logic [5:0] RD_TO_PRE_NCK = 6'(dctc_nck(RTP_PS, RTP_NCK));
  localparam logic [5:0] RDAP_TO_ACT_NCK = RD_TO_PRE_NCK + RP_NCK;
  localparam logic [5:0] MRS_GAP_NCK = 6'(MRD_NCK);
  localparam logic [5:0] MOD_GAP_NCK = 6'(dctc_nck(MOD_PS, MOD_NCK));
  localparam logic [5:0] MPR_GAP_NCK = 6'(RL_NCK + BURST_NCK + MPRR_NCK);
  localparam logic [5:0] PD_LOW_NCK = 6'(dctc_nck(CKE_PS, CKE_NCK));
  localparam logic [5:0] SR_LOW_NCK = PD_LOW_NCK + 6'(CKESR_EXTRA_NCK);
  localparam logic [5:0] CLK_HOLD_NCK = 6'(dctc_nck(CKSRE_PS, CKSRE_NCK));
  localparam logic [5:0] CLK_PRE_NCK = 6'(dctc_nck(CKSRX_PS, CKSRX_NCK));
  localparam logic [5:0] RFC_NCK = 6'(dctc_nck(RFC_PS, 1));
  localparam logic [5:0] XS_GAP_NCK = 6'(dctc_nck(RFC_PS + XS_EXTRA_PS, XS_NCK));

  // geometry
  localparam int BANKS = 8;
  localparam int FAW_SLOTS = 4;
  localparam int AP_BIT = 10;

  // request codes from the user side
  localparam logic [3:0] CMD_ACT = 4'h1;
  localparam logic [3:0] CMD_RD = 4'h2;
  localparam logic [3:0] CMD_WR = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h4;
  localparam logic [3:0] CMD_REF = 4'h5;
  localparam logic [3:0] CMD_MRS = 4'h6;
  localparam logic [3:0] CMD_MPR_RD = 4'h7;
  localparam logic [3:0] CMD_SR_ENTER = 4'h8;
  localparam logic [3:0] CMD_PD_ENTER = 4'h9;
  localparam logic [3:0] CMD_WAKE = 4'hA;

  // pin patterns {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_RD = 4'h5;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_MRS = 4'h0;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HOLD = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE = 4'h8
  } dctc_state_t;

endpackage

// File: tb_top.sv
/*
  tb_top: self-checking bench for dctc_host_ctrl with the device model on
  its memory pins. Assumes the controller derives the memory clock itself.
*/
`timescale 1ns/1ps
module tb_top;
  import dctc_pkg::*;
  typedef struct {
    logic [3:0] pins;
    logic [2:0] bank;
    logic [15:0] addr;
    int gap;
    bit pin_chk;
  } dctc_note_t;
  logic ref_clk = 1'b0;
  logic resetn, req_valid, req_ack, sleep_active, mem_ck, mem_ck_n, mem_cke;
  logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [3:0] req_cmd;
  logic [2:0] req_bank, mem_ba;
  logic [15:0] req_addr, mem_addr;
  logic [31:0] lfsr_state = 32'h19D0;
  int bad_count = 0, compares = 0, tick = 0, last_ack = 0, mdl_err;
  dctc_note_t notes[$];

  always #12.5 ref_clk = ~ref_clk;

  dctc_host_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_ack(req_ack),
    .sleep_active(sleep_active), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_addr(mem_addr));

  dctc_mem_model mdl (.mem_ck(mem_ck), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .err_count(mdl_err));

  // next pseudo-random word; bit 10 cleared so plain reads and writes stay open
  function automatic logic [15:0] rnd16();
    lfsr_state = {lfsr_state[30:0],
      lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state[15:0] & 16'hFBFF;
  endfunction

  task automatic compare_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // spacing is a floor, so the measured gap may exceed the expected one
  task automatic compare_min(input int got, input int lo);
    compares++;
    if (got < lo)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t gap=%h min=%h", $time, got, lo);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one request, held until acknowledged; the note carries the floor in ref cycles
  task automatic issue(input logic [3:0] cmd, input logic [2:0] bank, input logic [15:0] addr,
    input logic [3:0] pins, input bit pin_chk, input int gap_nck);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_bank <= bank;
    req_addr <= addr;
    notes.push_back('{pins, bank, addr, 2 * gap_nck, pin_chk});
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (req_ack !== 1'b1 && n < 600);
    req_valid <= 1'b0;
    if (n >= 600)
      compare_val(8'h00, 8'h01);
  endtask

  // a request that must never be taken; any ack finds an empty queue
  task automatic hold_off(input logic [3:0] cmd);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    repeat (40) @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask

  // watch acks: pins and bank stand in the ack cycle, gap measured ack to ack
  always @(posedge ref_clk)
  begin
    dctc_note_t n;
    tick++;
    if (req_ack === 1'b1)
    begin
      compare_val(8'(notes.size()), 8'h01);
      if (notes.size() > 0)
      begin
        n = notes.pop_front();
        if (n.pin_chk)
          compare_val({4'h0, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}, {4'h0, n.pins});
        if (n.pin_chk)
          compare_val({5'h00, mem_ba}, {5'h00, n.bank});
        if (n.pin_chk)
          compare_val(mem_addr[15:8], n.addr[15:8]);
        if (n.pin_chk)
          compare_val(mem_addr[7:0], n.addr[7:0]);
        compare_val({7'h00, mem_ck_n}, {7'h00, ~mem_ck});
        compare_min(tick - last_ack, n.gap);
      end
      last_ack = tick;
    end
  end

  // cut a hang short well beyond the few hundred cycles the tests need
  initial
  begin
    #500000;
    bad_count++;
    final_report();
  end

  initial
  begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_bank = 3'h0;
    req_addr = 16'h0000;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    issue(CMD_MRS, 3'h0, rnd16(), PIN_MRS, 1'b1, 0);
    issue(CMD_MRS, 3'h1, rnd16(), PIN_MRS, 1'b1, MRS_GAP_NCK);
    issue(CMD_ACT, 3'h1, rnd16(), PIN_ACT, 1'b1, MOD_GAP_NCK);
    $display("test mode_set done");
    for (int b = 2; b < 6; b++)
      issue(CMD_ACT, 3'(b), rnd16(), PIN_ACT, 1'b1, ACT_GAP_NCK);
    $display("test activate done");
    issue(CMD_WR, 3'h1, rnd16(), PIN_WR, 1'b1, 0);
    issue(CMD_WR, 3'h2, rnd16(), PIN_WR, 1'b1, COL_GAP_NCK);
    issue(CMD_RD, 3'h1, rnd16(), PIN_RD, 1'b1, WR_TO_RD_NCK);
    issue(CMD_RD, 3'h2, rnd16(), PIN_RD, 1'b1, COL_GAP_NCK);
    issue(CMD_PRE, 3'h2, 16'h0000, PIN_PRE, 1'b1, RD_TO_PRE_NCK);
    issue(CMD_WR, 3'h3, rnd16(), PIN_WR, 1'b1, 0);
    issue(CMD_PRE, 3'h3, 16'h0000, PIN_PRE, 1'b1, WR_TO_PRE_NCK);
    issue(CMD_WR, 3'h4, rnd16() | 16'h0400, PIN_WR, 1'b1, 0);
    issue(CMD_ACT, 3'h4, rnd16(), PIN_ACT, 1'b1, WRAP_TO_ACT_NCK);
    issue(CMD_RD, 3'h5, rnd16() | 16'h0400, PIN_RD, 1'b1, 0);
    issue(CMD_ACT, 3'h5, rnd16(), PIN_ACT, 1'b1, RDAP_TO_ACT_NCK);
    $display("test column done");
    issue(CMD_MPR_RD, 3'h0, 16'h0000, PIN_RD, 1'b1, 0);
    issue(CMD_PRE, 3'h1, 16'h0000, PIN_PRE, 1'b1, MPR_GAP_NCK);
    issue(CMD_REF, 3'h0, 16'h0000, PIN_REF, 1'b1, 0);
    issue(CMD_REF, 3'h0, 16'h0000, PIN_REF, 1'b1, RFC_NCK);
    $display("test pattern_refresh done");
    issue(CMD_SR_ENTER, 3'h0, 16'h0000, PIN_REF, 1'b1, RFC_NCK);
    hold_off(CMD_ACT);
    compare_val({7'h00, sleep_active}, 8'h01);
    compare_val({7'h00, mem_cke}, 8'h00);
    issue(CMD_WAKE, 3'h0, 16'h0000, 4'h0, 1'b0, SR_LOW_NCK);
    issue(CMD_ACT, 3'h6, rnd16(), PIN_ACT, 1'b1, XS_GAP_NCK);
    repeat (4) @(posedge ref_clk);
    compare_val({7'h00, sleep_active}, 8'h00);
    $display("test self_refresh done");
    issue(CMD_PD_ENTER, 3'h0, 16'h0000, 4'h0, 1'b0, 0);
    repeat (20) @(posedge ref_clk);
    compare_val({7'h00, sleep_active}, 8'h01);
    issue(CMD_WAKE, 3'h0, 16'h0000, 4'h0, 1'b0, PD_LOW_NCK);
    repeat (4) @(posedge ref_clk);
    compare_val({7'h00, mem_cke}, 8'h01);
    hold_off(4'hF);
    $display("test power_down done");
    compare_val(8'(mdl_err), 8'h00);
    final_report();
  end
endmodule
